/* hw/power_supply_adc_telemetry.sv */
// supply telemetry: two eight-channel converters as bus slaves on one link
`timescale 1ns/1ns
`default_nettype none
// Operation
// - controller is master, converters only slaves
// - return the requested converter/channel sample if single-ended, on a used channel and captured, else zero
// - first converter answers address 0x4A
// - second converter answers address 0x49
// - converter one: panel volts, tracker volts, unused
// - converter two: temperatures and tracker current
// - measurements referred to internal 2.5 V reference
module power_supply_adc_telemetry (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// link pins: clock from the master, open-drain data
	input wire logic sclLink,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// fitted converters, bit 0 first converter
	input wire logic [1:0] converterPresent,
	// live conversion results per channel
	input wire psu_telemetry_pkg::sample_bank_t conv1Samples,
	input wire psu_telemetry_pkg::sample_bank_t conv2Samples,
	// status of the last accepted command
	output logic selConverter,
	output logic [2:0] selChannel,
	output logic converterPowered,
	output logic referencePowered,
	output logic singleEnded,
	output logic conversionStrobe
);
	import psu_telemetry_pkg::*;

	psu_link_if link ();
	assign link.sdaIn = sdaIn;
	assign link.sclIn = sclLink;
	start_detect u_start (
		.link(link)
	);

	// link-domain copies of reset, presence and the capture acknowledge, and the system-domain request copy
	logic rstLink;
	logic [1:0] presentLink;
	logic ackSync;
	logic reqSync;
	// link-domain registers
	link_state_t state_q, state_d;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic rw_q, rw_d;
	logic devSel_q, devSel_d;
	logic [7:0] cmd_q, cmd_d;
	logic reqTog_q, reqTog_d;
	logic startSeen_q, startSeen_d;
	logic [7:0] txByte_q, txByte_d;
	logic [11:0] txWord_q, txWord_d;
	logic loByte_q, loByte_d;
	logic sdaOe_q, sdaOe_d;
	logic sdaOut_q;
	// system-domain registers
	logic reqSeen_q, reqSeen_d;
	logic ackTog_q, ackTog_d;
	logic [1:0][11:0] heldWord_q, heldWord_d;
	logic selConv_q, selConv_d;
	logic [2:0] selCh_q, selCh_d;
	logic convPwr_q, convPwr_d;
	logic refPwr_q, refPwr_d;
	logic single_q, single_d;
	logic strobe_q, strobe_d;

	sync_two_stage #(.WIDTH(1)) u_rstSync (
		.clk(sclLink),
		.async(sys_rst),
		.synced(rstLink)
	);
	sync_two_stage #(.WIDTH(2)) u_presentSync (
		.clk(sclLink),
		.async(converterPresent),
		.synced(presentLink)
	);
	sync_two_stage #(.WIDTH(1)) u_ackSync (
		.clk(sclLink),
		.async(ackTog_q),
		.synced(ackSync)
	);
	sync_two_stage #(.WIDTH(1)) u_reqSync (
		.clk(clk_sys),
		.async(reqTog_q),
		.synced(reqSync)
	);

	// address decode of the seven shifted-in address bits, used on the read/write bit edge
	logic hit1;
	logic hit2;
	assign hit1 = (shift_q[6:0] == CONV1_ADDR) && presentLink[CONV1_IDX];
	assign hit2 = (shift_q[6:0] == CONV2_ADDR) && presentLink[CONV2_IDX];
	// slave sequencing, sampled on the rising link clock edge
	always_comb
	begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		rw_d = rw_q;
		devSel_d = devSel_q;
		cmd_d = cmd_q;
		reqTog_d = reqTog_q;
		startSeen_d = startSeen_q;
		txByte_d = txByte_q;
		txWord_d = txWord_q;
		loByte_d = loByte_q;
		// a start, repeated or not, always wins and aborts any transfer
		if (link.startTog != startSeen_q)
		begin
			startSeen_d = link.startTog;
			state_d = ST_ADDR;
			shift_d = {7'h00, sdaIn};
			bitCnt_d = BIT_ONE;
		end
		else
		begin
			case (state_q)
				ST_ADDR:
				begin
					shift_d = {shift_q[6:0], sdaIn};
					bitCnt_d = bitCnt_q + BIT_ONE;
					if (bitCnt_q == LAST_BIT)
					begin
						// only ever a slave: no clock or start is driven
						if (hit1 || hit2)
						begin
							devSel_d = hit2;
							rw_d = sdaIn;
							state_d = ST_ADDR_ACK;
						end
						else
							state_d = ST_IDLE;
					end
				end
				ST_ADDR_ACK:
				begin
					bitCnt_d = BIT_ZERO;
					if (rw_q)
					begin
						// stale capture reads as zero rather than the wrong channel
						txWord_d = (ackSync == reqTog_q) ? heldWord_q[devSel_q] : ZERO_SAMPLE;
						txByte_d = {HI_PAD, txWord_d[11:8]};
						loByte_d = 1'b0;
						state_d = ST_TX;
					end
					else
						state_d = ST_CMD;
				end
				ST_CMD:
				begin
					shift_d = {shift_q[6:0], sdaIn};
					bitCnt_d = bitCnt_q + BIT_ONE;
					if (bitCnt_q == LAST_BIT)
					begin
						cmd_d = {shift_q[6:0], sdaIn};
						reqTog_d = ~reqTog_q;
						state_d = ST_CMD_ACK;
					end
				end
				ST_CMD_ACK:
				begin
					bitCnt_d = BIT_ZERO;
					state_d = ST_CMD;
				end
				ST_TX:
				begin
					bitCnt_d = bitCnt_q + BIT_ONE;
					if (bitCnt_q == LAST_BIT)
						state_d = ST_TX_ACK;
				end
				ST_TX_ACK:
				begin
					bitCnt_d = BIT_ZERO;
					if (!sdaIn)
					begin
						// further bytes alternate high and low halves of the same word
						loByte_d = ~loByte_q;
						txByte_d = loByte_q ? {HI_PAD, txWord_q[11:8]} : txWord_q[7:0];
						state_d = ST_TX;
					end
					else
						state_d = ST_IDLE;
				end
				default:
					state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sclLink)
	begin
		if (rstLink)
		begin
			state_q <= ST_IDLE;
			bitCnt_q <= BIT_ZERO;
			shift_q <= 8'h00;
			rw_q <= 1'b0;
			devSel_q <= 1'b0;
			cmd_q <= 8'h00;
			reqTog_q <= 1'b0;
			startSeen_q <= link.startTog;
			txByte_q <= 8'h00;
			txWord_q <= ZERO_SAMPLE;
			loByte_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			rw_q <= rw_d;
			devSel_q <= devSel_d;
			cmd_q <= cmd_d;
			reqTog_q <= reqTog_d;
			startSeen_q <= startSeen_d;
			txByte_q <= txByte_d;
			txWord_q <= txWord_d;
			loByte_q <= loByte_d;
		end
	end

	// data line drive changes only while the link clock is low
	always_comb
	begin
		sdaOe_d = 1'b0;
		case (state_q)
			ST_ADDR_ACK, ST_CMD_ACK:
				sdaOe_d = 1'b1;
			ST_TX:
				sdaOe_d = ~txByte_q[3'(LAST_BIT - bitCnt_q)];
			default:
				sdaOe_d = 1'b0;
		endcase
	end

	// open drain: the output level stays low, only the enable moves
	always_ff @(negedge sclLink)
	begin
		sdaOut_q <= 1'b0;
		if (rstLink)
			sdaOe_q <= 1'b0;
		else
			sdaOe_q <= sdaOe_d;
	end
	assign sdaOe = sdaOe_q;
	assign sdaOut = sdaOut_q;

	// capture side: devSel_q and cmd_q are stable for many link bits once the
	// request toggle has crossed, so they are read here directly
	logic [2:0] reqCh;
	logic [11:0] reqSample;
	assign reqCh = cmd_q[CMD_CH_MSB:CMD_CH_LSB];
	always_comb
	begin
		reqSample = devSel_q ? conv2Samples[reqCh] : conv1Samples[reqCh];
		if (devSel_q == CONV1_IDX && reqCh == CH1_UNUSED)
			reqSample = ZERO_SAMPLE;
		// no differential measurement exists on this board
		if (!cmd_q[CMD_SINGLE_BIT])
			reqSample = ZERO_SAMPLE;
	end

	always_comb
	begin
		reqSeen_d = reqSeen_q;
		ackTog_d = ackTog_q;
		heldWord_d = heldWord_q;
		selConv_d = selConv_q;
		selCh_d = selCh_q;
		convPwr_d = convPwr_q;
		refPwr_d = refPwr_q;
		single_d = single_q;
		strobe_d = 1'b0;
		if (reqSync != reqSeen_q)
		begin
			reqSeen_d = reqSync;
			heldWord_d[devSel_q] = reqSample;
			selConv_d = devSel_q;
			selCh_d = reqCh;
			convPwr_d = cmd_q[CMD_PWR_BIT];
			refPwr_d = cmd_q[CMD_REF_BIT];
			single_d = cmd_q[CMD_SINGLE_BIT];
			strobe_d = 1'b1;
			ackTog_d = ~ackTog_q;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			reqSeen_q <= 1'b0;
			ackTog_q <= 1'b0;
			heldWord_q <= '0;
			selConv_q <= 1'b0;
			selCh_q <= BIT_ZERO;
			convPwr_q <= 1'b0;
			refPwr_q <= 1'b0;
			single_q <= 1'b0;
			strobe_q <= 1'b0;
		end
		else
		begin
			reqSeen_q <= reqSeen_d;
			ackTog_q <= ackTog_d;
			heldWord_q <= heldWord_d;
			selConv_q <= selConv_d;
			selCh_q <= selCh_d;
			convPwr_q <= convPwr_d;
			refPwr_q <= refPwr_d;
			single_q <= single_d;
			strobe_q <= strobe_d;
		end
	end

	assign selConverter = selConv_q;
	assign selChannel = selCh_q;
	assign converterPowered = convPwr_q;
	assign referencePowered = refPwr_q;
	assign singleEnded = single_q;
	assign conversionStrobe = strobe_q;
endmodule
`default_nettype wire

/* hw/psu_link_if.sv */
// carrier between the link pins and the start detector
`timescale 1ns/1ns
`default_nettype none
interface psu_link_if;
	logic sdaIn;
	logic sclIn;
	logic startTog;
	modport detect (input sdaIn, input sclIn, output startTog);
	modport slave (input sdaIn, input sclIn, input startTog);
endinterface
`default_nettype wire

/* hw/psu_telemetry_pkg.sv */
// shared constants and types for the supply converter telemetry slave
package psu_telemetry_pkg;
	localparam int SAMPLE_W = 12;
	localparam int CHANNELS = 8;
	localparam int BYTE_W = 8;

	// seven-bit bus addresses of the two converters
	localparam logic [6:0] CONV1_ADDR = 7'h4A;
	localparam logic [6:0] CONV2_ADDR = 7'h49;

	// command byte layout
	localparam int CMD_SINGLE_BIT = 7;
	localparam int CMD_CH_MSB = 6;
	localparam int CMD_CH_LSB = 4;
	localparam int CMD_REF_BIT = 3;
	localparam int CMD_PWR_BIT = 2;

	// converter one channel map
	localparam logic [2:0] CH1_POS_X_V = 3'h0;
	localparam logic [2:0] CH1_NEG_X_V = 3'h1;
	localparam logic [2:0] CH1_POS_Y_V = 3'h2;
	localparam logic [2:0] CH1_NEG_Y_V = 3'h3;
	localparam logic [2:0] CH1_POS_Z_V = 3'h4;
	localparam logic [2:0] CH1_NEG_Z_V = 3'h5;
	localparam logic [2:0] CH1_TRACKER_V = 3'h6;
	localparam logic [2:0] CH1_UNUSED = 3'h7;
	// converter two channel map
	localparam logic [2:0] CH2_BOARD_TEMP = 3'h0;
	localparam logic [2:0] CH2_NEG_Y_T = 3'h1;
	localparam logic [2:0] CH2_POS_Z_T = 3'h2;
	localparam logic [2:0] CH2_POS_X_T = 3'h3;
	localparam logic [2:0] CH2_TRACKER_I = 3'h4;
	localparam logic [2:0] CH2_POS_Y_T = 3'h5;
	localparam logic [2:0] CH2_NEG_X_T = 3'h6;
	localparam logic [2:0] CH2_NEG_Z_T = 3'h7;

	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] BIT_ONE = 3'h1;
	localparam logic [2:0] BIT_ZERO = 3'h0;
	localparam logic [11:0] ZERO_SAMPLE = 12'h000;
	localparam logic [3:0] HI_PAD = 4'h0;
	localparam logic CONV1_IDX = 1'b0;
	localparam logic CONV2_IDX = 1'b1;

	typedef logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_bank_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_CMD = 7'h08,
		ST_CMD_ACK = 7'h10,
		ST_TX = 7'h20,
		ST_TX_ACK = 7'h40
	} link_state_t;
endpackage

/* hw/start_detect.sv */
// start condition detector: data falling while the clock is high
`timescale 1ns/1ns
`default_nettype none
module start_detect (
	// link pins and start toggle
	psu_link_if.detect link
);
	// the data line is this flop's only clock, so no reset can reach it;
	// a known power-up value keeps the toggle comparison clean
	logic startTog_q = 1'b0;
	logic startTog_d;

	always_comb
	begin
		startTog_d = startTog_q;
		if (link.sclIn)
			startTog_d = ~startTog_q;
	end

	always_ff @(negedge link.sdaIn)
	begin
		startTog_q <= startTog_d;
	end

	assign link.startTog = startTog_q;
endmodule
`default_nettype wire

/* hw/sync_two_stage.sv */
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ns
`default_nettype none
module sync_two_stage #(
	parameter int WIDTH = 1
) (
	// destination clock
	input wire logic clk,
	// data
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk)
	begin
		meta_q <= async;
		sync_q <= meta_q;
	end

	assign synced = sync_q;
endmodule
`default_nettype wire

/* verification/power_supply_adc_telemetry_poll_tb.sv */
// self-checking bench for the supply converter telemetry slave
`timescale 1ns/1ns
`default_nettype none
module power_supply_adc_telemetry_poll_tb;
	import psu_telemetry_pkg::*;
	typedef struct {logic [6:0] addr; logic [7:0] cmd; logic [11:0] word;} row_t;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic sclLink;
	logic mSda;
	logic sdaIn;
	logic sdaOut;
	logic sdaOe;
	logic [1:0] converterPresent = 2'h3;
	sample_bank_t conv1Samples;
	sample_bank_t conv2Samples;
	logic selConverter;
	logic [2:0] selChannel;
	logic converterPowered;
	logic referencePowered;
	logic singleEnded;
	logic conversionStrobe;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int strobes = 0;
	row_t rows[16];
	logic [7:0] hi;
	logic [7:0] lo;
	logic ack;
	always #10 clk_sys = ~clk_sys;
	// an unknown enable is treated as released so reset sees an idle line
	assign sdaIn = mSda && sdaOe !== 1'h1;
	power_supply_adc_telemetry dut (.clk_sys, .sys_rst, .sclLink, .sdaIn, .sdaOut, .sdaOe,
		.converterPresent, .conv1Samples, .conv2Samples, .selConverter, .selChannel,
		.converterPowered, .referencePowered, .singleEnded, .conversionStrobe);
	psu_link_master m (.scl(sclLink), .sda(mSda), .sdaBus(sdaIn));
	task automatic summarize();
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (conversionStrobe === 1'h1)
			strobes <= strobes + 1;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end
	function automatic logic [11:0] expectWord(input logic cv, input logic [2:0] ch);
		if (!cv && ch == CH1_UNUSED)
			return 12'h000;
		return cv ? {4'h5, 1'h0, ch, 4'hC} : {4'hA, 1'h0, ch, 4'h5};
	endfunction
	task automatic check(input string n, input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic checkStatus(input logic cv, input logic [7:0] c);
		check("status", {5'h00, cv, c[6:4], c[7], c[3], c[2]},
			{5'h00, selConverter, selChannel, singleEnded, referencePowered, converterPowered});
	endtask
	task automatic writeCmd(input logic [6:0] a, input logic [7:0] c, input logic nak);
		int s;
		s = strobes;
		m.startBit();
		m.putByte({a, 1'h0}, ack);
		check("address ack", {11'h000, nak}, {11'h000, ack});
		if (!nak)
			m.putByte(c, ack);
		m.stopBit();
		settle(12);
		check("captures", nak ? 12'h000 : 12'h001, 12'(strobes - s));
	endtask
	task automatic readWord(input logic [6:0] a, input logic [11:0] e);
		m.startBit();
		m.putByte({a, 1'h1}, ack);
		m.getByte(1'h0, hi);
		m.getByte(1'h1, lo);
		m.stopBit();
		check("word", e, {hi[3:0], lo});
		check("pad", 12'h000, {8'h00, hi[7:4]});
	endtask
	initial
	begin
		for (int i = 0; i < 8; i++)
		begin
			conv1Samples[i] = {4'hA, 1'h0, 3'(i), 4'h5};
			conv2Samples[i] = {4'h5, 1'h0, 3'(i), 4'hC};
		end
		// ascending channels within each converter
		for (int i = 0; i < 16; i++)
			rows[i] = '{i[3] ? CONV2_ADDR : CONV1_ADDR, {1'h1, i[2:0], 4'hC},
				expectWord(i[3], i[2:0])};
		fork
			m.idle(5);
			repeat (20) @(posedge clk_sys);
		join
		sys_rst <= 1'h0;
		m.idle(2);
		settle(1);
		checkStatus(1'h0, 8'h00);
		readWord(CONV1_ADDR, 12'h000);
		foreach (rows[i]) // one full telemetry pass over both converters
		begin
			writeCmd(rows[i].addr, rows[i].cmd, 1'h0);
			checkStatus(rows[i].addr == CONV2_ADDR, rows[i].cmd);
			readWord(rows[i].addr, rows[i].word);
		end
		// acknowledging past the low byte starts the same word again
		m.startBit();
		m.putByte({CONV2_ADDR, 1'h1}, ack);
		m.getByte(1'h0, lo);
		m.getByte(1'h0, lo);
		m.getByte(1'h1, hi);
		m.stopBit();
		check("repeat high", 12'h005, {4'h0, hi});
		writeCmd(CONV2_ADDR, 8'h5C, 1'h0);
		checkStatus(1'h1, 8'h5C);
		readWord(CONV2_ADDR, 12'h000);
		@(posedge clk_sys);
		converterPresent <= 2'h1;
		writeCmd(CONV2_ADDR, 8'hFC, 1'h1);
		checkStatus(1'h1, 8'h5C);
		writeCmd(7'h48, 8'hFC, 1'h1);
		writeCmd(CONV1_ADDR, 8'hAC, 1'h0);
		readWord(CONV1_ADDR, 12'hA25);
		@(posedge clk_sys);
		sys_rst <= 1'h1;
		settle(2);
		checkStatus(1'h0, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire

/* verification/psu_link_master.sv */
// bus master model: clocks the link inside frames and during idle bit times
`timescale 1ns/1ns
`default_nettype none
module psu_link_master (
	// bus lines
	output logic scl,
	output logic sda,
	input wire logic sdaBus
);
	initial
	begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// data moves a little after the falling clock so it is never seen as a start
	task automatic bitIo(input logic b, output logic r); // bit time scaled down
		scl = 1'h0;
		#2 sda = b;
		#22 scl = 1'h1;
		#20 r = sdaBus;
		#4;
	endtask
	task automatic idle(input int n);
		logic r;
		repeat (n) bitIo(1'h1, r);
	endtask
	task automatic startBit();
		scl = 1'h0;
		#2 sda = 1'h1;
		#22 scl = 1'h1;
		#24 sda = 1'h0;
		#24;
	endtask
	task automatic stopBit();
		scl = 1'h0;
		#2 sda = 1'h0;
		#22 scl = 1'h1;
		#24 sda = 1'h1;
		#24;
	endtask
	task automatic putByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitIo(b[i], r);
		bitIo(1'h1, ack);
	endtask
	task automatic getByte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitIo(1'h1, b[i]);
		bitIo(last, r);
	endtask
endmodule
`default_nettype wire

/* verification/psu_telemetry_asserts.sv */
// concurrent checks on the supply telemetry slave's ports
`timescale 1ns/1ns
`default_nettype none
module psu_telemetry_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// link
	input wire logic sclLink,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// status
	input wire logic selConverter,
	input wire logic [2:0] selChannel,
	input wire logic converterPowered,
	input wire logic referencePowered,
	input wire logic singleEnded,
	input wire logic conversionStrobe
);
	logic [6:0] status;
	assign status = {selConverter, selChannel, converterPowered, referencePowered, singleEnded};
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// between frames the master parks its clock high
	sequence sclIdle;
		sclLink [*6];
	endsequence
	a_data_open_drain: assert property (!sdaOut)
		else $error("data output driven high");
	a_strobe_single: assert property (conversionStrobe |=> !conversionStrobe [*8])
		else $error("capture strobe repeated");
	a_status_cleared: assert property ($fell(sys_rst) |-> status == 7'h00 && !conversionStrobe)
		else $error("status not cleared by reset");
	a_status_on_capture: assert property ($changed(status) |->
		conversionStrobe || $past(conversionStrobe))
		else $error("status moved without a capture");
	a_oe_idle_gap: assert property (sclIdle |-> !sdaOe)
		else $error("data pulled between frames");
	a_oe_bit_hold: assert property ($rose(sdaOe) |-> sdaOe [*2])
		else $error("low bit shorter than a link bit");
	a_oe_release_hold: assert property ($fell(sdaOe) |-> !sdaOe [*2])
		else $error("released bit shorter than a link bit");
	a_oe_edge_timing: assert property ($changed(sdaOe) |-> !sclLink)
		else $error("data moved while link clock high");
	a_oe_stable_high: assert property (sclLink && $past(sclLink) |-> $stable(sdaOe))
		else $error("data unstable in clock high phase");
endmodule
bind power_supply_adc_telemetry psu_telemetry_asserts chk (.clk_sys, .sys_rst, .sclLink,
	.sdaOut, .sdaOe, .selConverter, .selChannel, .converterPowered, .referencePowered,
	.singleEnded, .conversionStrobe);
`default_nettype wire
